// ==== hw/rfi_map.vh ====
// Purpose: constants for the receiver fault indication block
// Assumes: 10 MHz clock, 8-bit temperature codes
// Notes:   fault bit positions follow the raw fault status layout
`ifndef RFI_MAP_VH
`define RFI_MAP_VH
// fault bit positions in the 8-bit status word
`define RFI_BIT_SHDN   0
`define RFI_BIT_EOC    2
`define RFI_BIT_DIE    5
`define RFI_BIT_TSA    6
`define RFI_BIT_TSB    7
`define RFI_FLT_W      8
`define RFI_FLT_ZERO   8'h00
// pin positions in the synchroniser vectors
`define RFI_PIN_SHDN   0
`define RFI_PIN_EOC    1
`define RFI_PIN_DIE    2
`define RFI_PIN_THS    3
`define RFI_PIN_N      4
`define RFI_PIN_IDLE   4'h0
// stop packet reason codes
`define RFI_RSN_EOC    8'h01
`define RFI_RSN_THERM  8'h02
`define RFI_RSN_TEMP   8'h03
`define RFI_RSN_NONE   8'h00
// default enable: all implemented faults on
`define RFI_EN_RST     8'hE5
// temperature code scale: source uA, full scale mV, counts
`define RFI_SRC_UA     100
`define RFI_FS_MV      1800
`define RFI_FS_CNT     255
`define RFI_CODE_MAX   8'hFF
`define RFI_CODE_RST   8'h00
// full-width product for the code conversion
`define RFI_PROD_W     32
`define RFI_CODE_MAX32 32'h000000FF
`endif

// ==== hw/rfi_fault_ind.v ====
// Purpose: fault status, interrupt pin, indicator pin and stop packet request
// Assumes: pin inputs are asynchronous; thermistor voltages arrive as mV words
// Notes:   open-drain pins expose out/oe; out is always low, oe high pulls low
//
// Operation
// [RQ1] indicator pin sinks only while linked and power is being delivered
// [RQ2] interrupt pin is open-drain and active low
// [RQ3] interrupt on shutdown, end of charge, die hot, remote temp trip, thermal stop
// [RQ4] interrupt pin released when no fault is present
// [RQ5] the cause of the interrupt is held in a readable status word
// [RQ6] end of charge high requests a stop packet to the transmitter
// [RQ7] transmitter enters standby and pings again after five minutes or removal
// [RQ8] two independent remote thermistor inputs are accepted
// [RQ9] each thermistor reading is digitised and readable by the host
// [RQ10] code is 100 uA times thermistor over 1.8 V, scaled to 255
// [RQ11] shutdown input high sends stop packet and puts output in high impedance
// [RQ12] enabled end-of-charge fault stops with reason code 0x01
// [RQ13] enabled remote temperature fault stops with reason code 0x03; code sends it only with no enabled end-of-charge, shutdown or heat fault
// [RQ14] interrupt asserts by pulling low, releases when all enabled causes clear
`timescale 1ns/10ps
`include "rfi_map.vh"

module rfi_fault_ind #(
  parameter MV_W = 12
) (
  // clock and reset
  input  wire                 clk,
  input  wire                 resetn,
  // asynchronous pins
  input  wire                 shutdown_in,
  input  wire                 end_of_charge,
  input  wire                 die_hot,
  input  wire                 thermal_stop,
  // receiver state
  input  wire                 link_up,
  input  wire                 power_flowing,
  // thermistor voltages in mV from the analog front end
  input  wire [MV_W-1:0]      temp_mv_a,
  input  wire [MV_W-1:0]      temp_mv_b,
  input  wire [7:0]           temp_limit_a,
  input  wire [7:0]           temp_limit_b,
  // configuration
  input  wire [7:0]           fault_enable,
  input  wire [7:0]           intr_enable,
  input  wire                 enable_load,
  // status towards the host interface
  output reg  [7:0]           fault_raw_q,
  output reg  [7:0]           intr_status_q,
  output reg  [7:0]           remote_temp_code_a_q,
  output reg  [7:0]           remote_temp_code_b_q,
  // stop packet request
  output reg                  power_stop_packet_q,
  output reg  [7:0]           power_stop_reason_q,
  output reg                  out_hiz_q,
  // open-drain pins
  output wire                 power_transfer_indicator_n_out,
  output reg                  power_transfer_indicator_n_oe_q,
  output wire                 intr_n_out,
  output reg                  intr_n_oe_q
);

  // pin synchroniser stages and the filtered pin levels
  reg  [`RFI_PIN_N-1:0]   s1_q;
  reg  [`RFI_PIN_N-1:0]   s2_q;
  reg  [`RFI_PIN_N-1:0]   s3_q;
  reg  [`RFI_PIN_N-1:0]   stable_q;
  reg  [`RFI_PIN_N-1:0]   stable_d;
  wire [`RFI_PIN_N-1:0]   pins;

  // enable masks, held until the next load strobe
  reg  [7:0]              fen_q;
  reg  [7:0]              ien_q;

  // thermistor codes and the combinational fault words
  wire [7:0]              code_a;
  wire [7:0]              code_b;
  reg  [7:0]              raw_d;
  reg  [7:0]              reason_d;
  wire [7:0]              masked_flt;
  wire [7:0]              masked_intr;
  wire                    any_flt;
  wire                    any_intr;
  wire                    delivering;

  // gather the four pins, one bit each
  assign pins[`RFI_PIN_SHDN] = shutdown_in;
  assign pins[`RFI_PIN_EOC]  = end_of_charge;
  assign pins[`RFI_PIN_DIE]  = die_hot;
  assign pins[`RFI_PIN_THS]  = thermal_stop;

  // plain three-flop shift; only stage two reads stage one
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= `RFI_PIN_IDLE;
      s2_q <= `RFI_PIN_IDLE;
      s3_q <= `RFI_PIN_IDLE;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a new level counts once stages two and three agree, else hold
  always @* begin
    stable_d = (s2_q & s3_q) | (stable_q & (s2_q | s3_q));
  end

  // filtered pin levels; idle low after reset so no false fault appears
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stable_q <= `RFI_PIN_IDLE;
    end else begin
      stable_q <= stable_d;
    end
  end

  // thermistor voltage to code: mv * 255 / 1800, saturated at full scale
  // the product is kept at full width so large voltages cannot wrap
  function [7:0] mv_to_code;
    input [MV_W-1:0]        mv;
    reg   [`RFI_PROD_W-1:0] prod;
    begin
      prod = ({{(`RFI_PROD_W-MV_W){1'b0}}, mv} * `RFI_FS_CNT) / `RFI_FS_MV; // RQ10
      if (prod > `RFI_CODE_MAX32)
        mv_to_code = `RFI_CODE_MAX;
      else
        mv_to_code = prod[7:0];
    end
  endfunction

  // codes for the two remote inputs, registered below
  assign code_a = mv_to_code(temp_mv_a);                                  // RQ9
  assign code_b = mv_to_code(temp_mv_b);                                  // RQ9

  // raw fault word; reserved positions stay zero
  always @* begin
    raw_d = `RFI_FLT_ZERO;
    raw_d[`RFI_BIT_SHDN] = stable_q[`RFI_PIN_SHDN];                       // RQ3
    raw_d[`RFI_BIT_EOC]  = stable_q[`RFI_PIN_EOC];                        // RQ3
    raw_d[`RFI_BIT_DIE]  = stable_q[`RFI_PIN_DIE] | stable_q[`RFI_PIN_THS]; // RQ3
    raw_d[`RFI_BIT_TSA]  = remote_temp_code_a_q > temp_limit_a;           // RQ8
    raw_d[`RFI_BIT_TSB]  = remote_temp_code_b_q > temp_limit_b;           // RQ8
  end

  // enabled views of the raw word for the stop packet and the interrupt
  assign masked_flt  = raw_d & fen_q;
  assign masked_intr = raw_d & ien_q;
  assign any_flt     = |masked_flt;
  assign any_intr    = |masked_intr;
  assign delivering  = link_up & power_flowing;                           // RQ1

  // stop reason; end of charge first, then shutdown or heat, then remote temp
  always @* begin
    if (masked_flt[`RFI_BIT_EOC]) begin
      reason_d = `RFI_RSN_EOC;                                            // RQ12
    end else if (masked_flt[`RFI_BIT_SHDN] | masked_flt[`RFI_BIT_DIE]) begin
      reason_d = `RFI_RSN_THERM;                                          // RQ11
    end else if (masked_flt[`RFI_BIT_TSA] | masked_flt[`RFI_BIT_TSB]) begin
      reason_d = `RFI_RSN_TEMP;                                           // RQ13
    end else begin
      reason_d = `RFI_RSN_NONE;
    end
  end

  // enable masks; a load takes effect from the following edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fen_q <= `RFI_EN_RST;
      ien_q <= `RFI_EN_RST;
    end else if (enable_load) begin
      fen_q <= fault_enable;
      ien_q <= intr_enable;
    end
  end

  // registered thermistor codes for the host
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_temp_code_a_q <= `RFI_CODE_RST;
      remote_temp_code_b_q <= `RFI_CODE_RST;
    end else begin
      remote_temp_code_a_q <= code_a;                                     // RQ9
      remote_temp_code_b_q <= code_b;                                     // RQ9
    end
  end

  // status words: levels that follow their causes, not sticky
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_raw_q   <= `RFI_FLT_ZERO;
      intr_status_q <= `RFI_FLT_ZERO;
    end else begin
      fault_raw_q   <= raw_d;                                             // RQ5
      intr_status_q <= masked_intr;                                       // RQ5
    end
  end

  // stop packet request and its reason, held while any enabled fault stands
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_stop_packet_q <= 1'b0;
      power_stop_reason_q <= `RFI_RSN_NONE;
    end else begin
      power_stop_packet_q <= any_flt;                                     // RQ6
      power_stop_reason_q <= reason_d;                                    // RQ12 RQ13
    end
  end

  // output high impedance follows the shutdown level, enabled or not
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_hiz_q <= 1'b0;
    end else begin
      out_hiz_q <= raw_d[`RFI_BIT_SHDN];                                  // RQ11
    end
  end

  // indicator sinks while delivering with no enabled fault standing
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_transfer_indicator_n_oe_q <= 1'b0;
    end else begin
      power_transfer_indicator_n_oe_q <= delivering & ~any_flt;           // RQ1
    end
  end

  // interrupt pulls low while any enabled cause stands, released otherwise
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      intr_n_oe_q <= 1'b0;
    end else begin
      intr_n_oe_q <= any_intr;                                            // RQ14 RQ4
    end
  end

  // open-drain pins only ever drive low; the enable decides
  assign power_transfer_indicator_n_out = 1'b0;                           // RQ1
  assign intr_n_out                     = 1'b0;                           // RQ2

endmodule // rfi_fault_ind

// ==== verification/rfi_fault_ind_sva.sv ====
// Purpose: port checker for the fault indication block
// Assumes: one clock, asynchronous active-low reset
// Notes:   pin causes settle within eight edges
`timescale 1ns/10ps
module rfi_fault_ind_sva (
  // watched ports
  input logic       clk, resetn, shutdown_in, end_of_charge, link_up, power_flowing,
  input logic [7:0] fault_raw_q, intr_status_q, power_stop_reason_q,
  input logic       power_stop_packet_q, out_hiz_q, intr_n_out, intr_n_oe_q,
  input logic       power_transfer_indicator_n_out, power_transfer_indicator_n_oe_q);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // pin drive, interrupt cause and stop reasons
  chk_pins_low: assert property (!intr_n_out && !power_transfer_indicator_n_out)
    else $error("pin drive");
  chk_intr_cause: assert property (intr_n_oe_q == |intr_status_q) else $error("intr");
  chk_intr_idle: assert property (fault_raw_q == 8'h00 |-> !intr_n_oe_q) else $error("idle");
  chk_status_raw: assert property ((intr_status_q & ~fault_raw_q) == 8'h00) else $error("sts");
  chk_eoc_seen: assert property (end_of_charge[*8] |-> fault_raw_q[2]) else $error("eoc");
  chk_eoc_reason: assert property (power_stop_reason_q == 8'h01 |-> fault_raw_q[2]
    && power_stop_packet_q) else $error("rsn 01");
  chk_temp_reason: assert property (power_stop_reason_q == 8'h03 |-> |fault_raw_q[7:6])
    else $error("rsn 03");
  chk_shdn_hiz: assert property (shutdown_in[*8] |-> out_hiz_q) else $error("hiz");
  chk_ind_idle: assert property ((!(link_up && power_flowing))[*3]
    |-> !power_transfer_indicator_n_oe_q) else $error("indicator");
endmodule // rfi_fault_ind_sva
bind rfi_fault_ind rfi_fault_ind_sva u_sva (.*);

// ==== verification/rfi_tx_model.sv ====
// Purpose: transmitter stand-in driving the link state
// Assumes: the stop request is a level
// Notes:   standby shortened to STBY cycles
`timescale 1ns/10ps
module rfi_tx_model #(parameter STBY = 40) (
  input wire    clk, resetn, stop,
  output logic  link_up, power_flowing);
  int cnt;
  // standby after a stop packet, then ping and link again
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin cnt <= 0; link_up <= 0; end
    else if (stop && link_up) begin cnt <= STBY; link_up <= 0; end
    else if (cnt != 0) cnt <= cnt - 1;
    else link_up <= 1;
  end
  assign power_flowing = link_up;
endmodule // rfi_tx_model

// ==== verification/rx_fault_indication_bench.sv ====
// Purpose: self-checking bench for the fault indication block
// Assumes: default masks E5 after reset
// Notes:   notes queue, compared on each look event
`timescale 1ns/10ps
module rx_fault_indication_bench;
  logic clk = 0, resetn = 0, ld = 0;
  logic [3:0] pin = 0;
  logic [11:0] mva = 0, mvb = 0;
  logic [7:0] lima = 8'hFF, limb = 8'hFF, fen = 8'hE5, ien = 8'hE5, t;
  logic [10:0] q[$], n;
  logic [31:0] r = 32'h5CF5;
  wire [7:0] raw, sts, ca, cb, rsn;
  wire lnk, pwr, stp, hiz, ind_oe, int_oe;
  int error_cnt = 0, checks_done = 0, cyc = 0;
  event look;
  rfi_fault_ind u_dut (.clk(clk), .resetn(resetn), .shutdown_in(pin[0]),
    .end_of_charge(pin[1]), .die_hot(pin[2]), .thermal_stop(pin[3]), .link_up(lnk),
    .power_flowing(pwr), .temp_mv_a(mva), .temp_mv_b(mvb), .temp_limit_a(lima),
    .temp_limit_b(limb), .fault_enable(fen), .intr_enable(ien), .enable_load(ld),
    .fault_raw_q(raw), .intr_status_q(sts), .remote_temp_code_a_q(ca),
    .remote_temp_code_b_q(cb), .power_stop_packet_q(stp), .power_stop_reason_q(rsn),
    .out_hiz_q(hiz), .power_transfer_indicator_n_out(),
    .power_transfer_indicator_n_oe_q(ind_oe), .intr_n_out(), .intr_n_oe_q(int_oe));
  rfi_tx_model u_tx (.clk(clk), .resetn(resetn), .stop(stp), .link_up(lnk), .power_flowing(pwr));
  always #50 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  function automatic int code(logic [11:0] mv);
    return mv * 255 / 1800 > 255 ? 255 : mv * 255 / 1800;
  endfunction
  task note(input [2:0] s, input [7:0] v); q.push_back({s, v}); endtask
  task tally(input [7:0] g, input [7:0] e, input string what);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task cmp_raw(input [7:0] e); tally(raw, e, "raw fault word"); endtask
  task cmp_sts(input [7:0] e); tally(sts, e, "interrupt cause"); endtask
  task cmp_rsn(input [7:0] e); tally(rsn, e, "stop reason"); endtask
  task cmp_code(input [7:0] g, input [7:0] e); tally(g, e, "thermistor code"); endtask
  task cmp_flags(input [7:0] e); tally({5'h00, stp, hiz, int_oe}, e, "stop hiz intr"); endtask
  task cmp_ind(input [7:0] e); tally({7'h00, ind_oe}, e, "indicator"); endtask
  task end_sim;
    if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // at the falling edge after a look, take every note off the queue
  always @(look) begin
    @(negedge clk);
    while (q.size() != 0) begin
      n = q.pop_front();
      case (n[10:8])
        3'd0: cmp_raw(n[7:0]);
        3'd1: cmp_sts(n[7:0]);
        3'd2: cmp_rsn(n[7:0]);
        3'd3: cmp_code(ca, n[7:0]);
        3'd4: cmp_code(cb, n[7:0]);
        3'd5: cmp_flags(n[7:0]);
        default: cmp_ind(n[7:0]);
      endcase
    end
  end
  always @(posedge clk) if (++cyc == 1000) begin error_cnt++; end_sim(); end
  // pins one by one, thermistor sweep, then masked end of charge
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pin <= 4'h1 << i;
      repeat (8) @(posedge clk);
      t = i == 0 ? 8'h01 : i == 1 ? 8'h04 : 8'h20;
      note(0, t); note(1, t); note(2, i == 1 ? 8'h01 : 8'h02);
      note(5, i == 0 ? 8'h07 : 8'h05); note(6, 8'h00); -> look;
      @(posedge clk) pin <= 0;
      repeat (8) @(posedge clk);
      note(0, 8'h00); note(1, 8'h00); note(2, 8'h00); note(5, 8'h00); -> look;
    end
    for (int i = 0; i < 6; i++) begin
      r = nx(r); mva <= i ? r[11:0] : 12'h708; lima <= r[23:16];
      r = nx(r); mvb <= i ? r[11:0] : 12'hFFF; limb <= r[23:16];
      repeat (4) @(posedge clk);
      t = {code(mvb) > limb, code(mva) > lima, 6'h00};
      note(3, code(mva)); note(4, code(mvb)); note(0, t); note(1, t);
      note(2, t ? 8'h03 : 8'h00); note(5, t ? 8'h05 : 8'h00); -> look;
    end
    mva <= 0; mvb <= 0; fen <= 0; ien <= 0; ld <= 1;
    @(posedge clk) ld <= 0; pin <= 4'h2;
    // long enough for the transmitter to leave standby and link again
    repeat (60) @(posedge clk);
    note(0, 8'h04); note(1, 8'h00); note(2, 8'h00); note(5, 8'h00); note(6, 8'h01); -> look;
    @(posedge clk) end_sim();
  end
endmodule // rx_fault_indication_bench
